// ===== shared/lpm_regs.vh
// Register map, field positions, reset values and timing counts of the line period monitor.
`ifndef LPM_REGS_VH
`define LPM_REGS_VH

// Register byte offsets on the APB bus.
`define LPM_CFG_OFS 8'h00
`define LPM_MODE_OFS 8'h04
`define LPM_STAT_OFS 8'h08
`define LPM_CMD_OFS 8'h0c
`define LPM_PER0_OFS 8'h10
`define LPM_PER1_OFS 8'h14
`define LPM_PER2_OFS 8'h18

// Configuration register fields.
`define LPM_CFG_MASTER_DIVIDER_SELECT_BIT 0
`define LPM_CFG_FAMILY_BIT 1
`define LPM_CFG_COMPCLK_BIT 2
`define LPM_CFG_PULSE_BIT 3
`define LPM_CFG_W 4
`define LPM_CFG_RST 4'h0

// Mode register fields.
`define LPM_MODE_APL_BIT 0
`define LPM_MODE_COMP_BIT 1
`define LPM_MODE_W 2
`define LPM_MODE_RST 2'h0

// Status register fields.
`define LPM_STAT_HALT_BIT 0
`define LPM_STAT_ERR_LSB 1
`define LPM_STAT_ANY_BIT 4
`define LPM_STAT_LOW_LSB 5

// Command register fields.
`define LPM_CMD_RESET_BIT 0

// Period meter limits, in master clock / 8 pulses.
`define LPM_PERIOD_W 19
`define LPM_PERIOD_MAX 19'h4_0000
`define LPM_PERIOD_MIN 19'h1_0000
`define LPM_PERIOD_DEFAULT 19'h2_0000
`define LPM_FAST_REPEAT 2'h3
`define LPM_PSC_LAST 3'h7

// Voltage level thresholds of the RMS voltage register.
`define LPM_LOW_SET 12'h0080
`define LPM_LOW_CLR 12'h0100

// Power-on release delay: 125 ms of master clock at 8389 kHz, sized to the counter.
`define LPM_POR_DELAY_MS 125
`define LPM_MCLK_KHZ 8389
`define LPM_POR_DELAY_TICKS 21'h10_0031
`define LPM_POR_CNT_W 21

`endif

// ===== logic/line_period_monitor.v
// Reset sequencing, clock derivation and line period monitoring with an APB register file.
`timescale 1ns/1ps
`include "lpm_regs.vh"

//////////////////////////////////////////////////////////////////////////////////////////////

//////////////////////////////////////////////////////////////////////////////////////////////
// One phase: slope, zero-cross, period meter, low voltage and frequency error.
module phase_period_meter (
    input wire i_clk,
    input wire i_rst,
    input wire i_sample_valid,
    input wire [15:0] i_sample,
    input wire [11:0] i_rms_voltage,
    input wire i_period_tick,
    output reg o_slope_r,
    output reg o_zero_cross_r,
    output reg o_frequency_error_r,
    output reg o_low_voltage_r,
    output reg [`LPM_PERIOD_W-1:0] o_period_r
);
    reg signed [15:0] prev_r;
    reg [`LPM_PERIOD_W-1:0] count_r;
    reg [1:0] fast_r;
    reg slope_d_r;
    wire slope_fall;
    wire rising;
    assign rising = $signed(i_sample) > prev_r;
    assign slope_fall = slope_d_r & ~o_slope_r;
    always @(posedge i_clk) begin
        if (i_rst) begin
            prev_r <= 16'sh0000;
            o_slope_r <= 1'b0;
            slope_d_r <= 1'b0;
            o_zero_cross_r <= 1'b0;
            count_r <= {`LPM_PERIOD_W{1'b0}};
            fast_r <= 2'h0;
            o_frequency_error_r <= 1'b1;
            o_low_voltage_r <= 1'b1;
            o_period_r <= `LPM_PERIOD_DEFAULT;
        end else begin
            slope_d_r <= o_slope_r;
            if (i_sample_valid) begin
                prev_r <= $signed(i_sample);
                if ($signed(i_sample) != prev_r) begin
                    o_slope_r <= rising;
                    o_zero_cross_r <= rising ^ ~i_sample[15];
                end
            end
            if (i_rms_voltage < `LPM_LOW_SET) begin
                o_low_voltage_r <= 1'b1;
            end else if (i_rms_voltage > `LPM_LOW_CLR) begin
                o_low_voltage_r <= 1'b0;
            end
            if (slope_fall) begin
                count_r <= {`LPM_PERIOD_W{1'b0}};
                if (count_r < `LPM_PERIOD_MIN) begin
                    if (fast_r == `LPM_FAST_REPEAT - 2'h1) begin
                        o_frequency_error_r <= 1'b1;
                        o_period_r <= `LPM_PERIOD_DEFAULT;
                    end else begin
                        fast_r <= fast_r + 2'h1;
                    end
                end else if (count_r <= `LPM_PERIOD_MAX) begin
                    fast_r <= 2'h0;
                    if (!o_low_voltage_r) begin
                        o_frequency_error_r <= 1'b0;
                        o_period_r <= count_r;
                    end
                end
            end else if (i_period_tick && count_r <= `LPM_PERIOD_MAX) begin
                count_r <= count_r + {{(`LPM_PERIOD_W-1){1'b0}}, 1'b1};
            end
            if (count_r > `LPM_PERIOD_MAX || o_low_voltage_r) begin
                o_frequency_error_r <= 1'b1;
                o_period_r <= `LPM_PERIOD_DEFAULT;
            end
        end
    end
endmodule // phase_period_meter
//////////////////////////////////////////////////////////////////////////////////////////////
// Top: reset sequencer, clock generator, three phase meters and APB registers.
module line_period_monitor #(
    parameter [`LPM_POR_CNT_W-1:0] POR_DELAY_TICKS = `LPM_POR_DELAY_TICKS
) (
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_power_on_detect,
    input wire i_crystal_input,
    input wire i_sample_valid,
    input wire [47:0] i_voltage_samples,
    input wire [35:0] i_rms_voltages,
    input wire [2:0] i_single_wire_mode,
    input wire i_pulse_motor_positive,
    input wire i_pulse_motor_negative,
    input wire i_pulse_energy,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    output reg o_core_reset,
    output reg o_reset_halt_flag,
    output reg o_master_tick,
    output reg o_companion_clock,
    output reg o_motor_positive_output,
    output reg o_motor_negative_output,
    output reg o_energy_pulse_output,
    output wire [2:0] o_frequency_error_flag,
    output reg o_any_phase_frequency_error,
    output reg [2:0] o_power_zero,
    output reg [2:0] o_energy_hold
);
    localparam [2:0] ST_RUN = 3'b001;
    localparam [2:0] ST_HOLD = 3'b010;
    localparam [2:0] ST_DELAY = 3'b100;
    reg por_s1_r;
    reg por_s2_r;
    reg xtal_s1_r;
    reg xtal_s2_r;
    reg xtal_s3_r;
    reg [2:0] state_r;
    reg [`LPM_POR_CNT_W-1:0] por_cnt_r;
    reg remote_r;
    reg [`LPM_CFG_W-1:0] cfg_r;
    reg [`LPM_MODE_W-1:0] mode_r;
    reg [2:0] psc_r;
    reg comp_div_r;
    wire xtal_rise;
    wire xtal_fall;
    wire mtick;
    wire ptick;
    wire access;
    wire wr_en;
    wire [2:0] slope;
    wire [2:0] zc;
    wire [2:0] low;
    wire [3*`LPM_PERIOD_W-1:0] period;
    reg [31:0] rdata;
    reg rmapped;
    //////////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            por_s1_r <= 1'b1;
            por_s2_r <= 1'b1;
            xtal_s1_r <= 1'b0;
            xtal_s2_r <= 1'b0;
            xtal_s3_r <= 1'b0;
        end else begin
            por_s1_r <= i_power_on_detect;
            por_s2_r <= por_s1_r;
            xtal_s1_r <= i_crystal_input;
            xtal_s2_r <= xtal_s1_r;
            xtal_s3_r <= xtal_s2_r;
        end
    end
    assign xtal_rise = xtal_s2_r & ~xtal_s3_r;
    assign xtal_fall = ~xtal_s2_r & xtal_s3_r;
    // master tick on one or both crystal edges
    assign mtick = cfg_r[`LPM_CFG_MASTER_DIVIDER_SELECT_BIT] ? xtal_rise : (xtal_rise | xtal_fall);
    assign ptick = mtick & (psc_r == `LPM_PSC_LAST);
    //////////////////////////////////////////////////////////////////////////////////////////
    // Reset sequencer.
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_r <= ST_HOLD;
            por_cnt_r <= {`LPM_POR_CNT_W{1'b0}};
            o_core_reset <= 1'b1;
            o_reset_halt_flag <= 1'b1;
        end else begin
            case (state_r)
                ST_RUN: begin
                    if (por_s2_r) begin
                        state_r <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    por_cnt_r <= {`LPM_POR_CNT_W{1'b0}};
                    if (!por_s2_r) begin
                        state_r <= ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    if (por_s2_r) begin
                        state_r <= ST_HOLD;
                    end else if (por_cnt_r >= POR_DELAY_TICKS) begin
                        state_r <= ST_RUN;
                    end else if (mtick) begin
                        por_cnt_r <= por_cnt_r + {{(`LPM_POR_CNT_W-1){1'b0}}, 1'b1};
                    end
                end
                default: begin
                    state_r <= ST_HOLD;
                end
            endcase
            o_core_reset <= (state_r != ST_RUN) | remote_r;
            o_reset_halt_flag <= (state_r != ST_RUN) | remote_r;
        end
    end
    //////////////////////////////////////////////////////////////////////////////////////////
    // Clock generator.
    always @(posedge i_clk) begin
        if (o_core_reset) begin
            psc_r <= 3'h0;
            comp_div_r <= 1'b0;
            o_companion_clock <= 1'b0;
            o_master_tick <= 1'b0;
        end else begin
            o_master_tick <= mtick;
            psc_r <= psc_r + {2'h0, mtick};
            if (xtal_rise) begin
                comp_div_r <= ~comp_div_r;
                if (cfg_r[`LPM_CFG_COMPCLK_BIT] || comp_div_r) begin
                    o_companion_clock <= ~o_companion_clock;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // Phase meters.
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : phase
            phase_period_meter u_meter (
                .i_clk(i_clk),
                .i_rst(o_core_reset),
                .i_sample_valid(i_sample_valid),
                .i_sample(i_voltage_samples[16*g+15:16*g]),
                .i_rms_voltage(i_rms_voltages[12*g+11:12*g]),
                .i_period_tick(ptick),
                .o_slope_r(slope[g]),
                .o_zero_cross_r(zc[g]),
                .o_frequency_error_r(o_frequency_error_flag[g]),
                .o_low_voltage_r(low[g]),
                .o_period_r(period[`LPM_PERIOD_W*g+`LPM_PERIOD_W-1:`LPM_PERIOD_W*g])
            );
        end
    endgenerate
    //////////////////////////////////////////////////////////////////////////////////////////
    // Output stage.
    always @(posedge i_clk) begin
        if (o_core_reset) begin
            o_motor_positive_output <= 1'b0;
            o_motor_negative_output <= 1'b0;
            o_energy_pulse_output <= 1'b0;
            o_any_phase_frequency_error <= 1'b1;
            o_power_zero <= 3'h7;
            o_energy_hold <= 3'h7;
        end else begin
            o_any_phase_frequency_error <= |o_frequency_error_flag;
            o_power_zero <= o_frequency_error_flag & ~i_single_wire_mode;
            o_energy_hold <= o_frequency_error_flag & ~i_single_wire_mode;
            if (!mode_r[`LPM_MODE_APL_BIT]) begin
                o_motor_positive_output <= ~(zc[0] ^ zc[1] ^ zc[2]);
            end else if (cfg_r[`LPM_CFG_PULSE_BIT]) begin
                o_motor_positive_output <= i_pulse_motor_positive & ~(|o_frequency_error_flag);
            end else begin
                o_motor_positive_output <= i_pulse_motor_positive;
            end
            if (cfg_r[`LPM_CFG_PULSE_BIT]) begin
                o_motor_negative_output <= i_pulse_motor_negative & ~(|o_frequency_error_flag);
                o_energy_pulse_output <= i_pulse_energy & ~(|o_frequency_error_flag);
            end else begin
                o_motor_negative_output <= i_pulse_motor_negative;
                o_energy_pulse_output <= i_pulse_energy;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // APB slave; the bus side survives every reset but the system one.
    assign access = i_psel & i_penable & ~o_pready;
    assign wr_en = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;
    always @* begin
        rdata = 32'h0000_0000;
        rmapped = 1'b1;
        case (i_paddr)
            `LPM_CFG_OFS: rdata[`LPM_CFG_W-1:0] = cfg_r;
            `LPM_MODE_OFS: rdata[`LPM_MODE_W-1:0] = mode_r;
            `LPM_STAT_OFS: begin
                rdata[`LPM_STAT_HALT_BIT] = o_reset_halt_flag;
                rdata[`LPM_STAT_ERR_LSB+2:`LPM_STAT_ERR_LSB] = o_frequency_error_flag;
                rdata[`LPM_STAT_ANY_BIT] = o_any_phase_frequency_error;
                rdata[`LPM_STAT_LOW_LSB+2:`LPM_STAT_LOW_LSB] = low;
            end
            `LPM_CMD_OFS: rdata = 32'h0000_0000;
            `LPM_PER0_OFS: rdata[`LPM_PERIOD_W-1:0] = period[`LPM_PERIOD_W-1:0];
            `LPM_PER1_OFS: rdata[`LPM_PERIOD_W-1:0] = period[2*`LPM_PERIOD_W-1:`LPM_PERIOD_W];
            `LPM_PER2_OFS: rdata[`LPM_PERIOD_W-1:0] = period[3*`LPM_PERIOD_W-1:2*`LPM_PERIOD_W];
            default: rmapped = 1'b0;
        endcase
    end
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
            remote_r <= 1'b0;
        end else begin
            o_pready <= access;
            o_pslverr <= access & ~rmapped;
            o_prdata <= (access & ~i_pwrite & rmapped) ? rdata : 32'h0000_0000;
            remote_r <= wr_en & (i_paddr == `LPM_CMD_OFS) & i_pwdata[`LPM_CMD_RESET_BIT];
        end
    end
    // shadow configuration cleared by any reset
    always @(posedge i_clk) begin
        if (o_core_reset) begin
            cfg_r <= `LPM_CFG_RST;
        end else if (wr_en && i_paddr == `LPM_CFG_OFS) begin
            cfg_r <= i_pwdata[`LPM_CFG_W-1:0];
        end
    end
    // mode bits cleared by system reset or power-on only, not by remote reset
    always @(posedge i_clk) begin
        if (i_sys_rst || state_r == ST_HOLD) begin
            mode_r <= `LPM_MODE_RST;
        end else if (wr_en && i_paddr == `LPM_MODE_OFS) begin
            mode_r <= i_pwdata[`LPM_MODE_W-1:0];
        end
    end
endmodule // line_period_monitor

// ===== dv/lpm_checker_sva.sv
// Port-level assertions for the line period monitor.
`timescale 1ns/1ps
`include "lpm_regs.vh"

module lpm_checker (
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_power_on_detect,
    input wire [35:0] i_rms_voltages,
    input wire [2:0] i_single_wire_mode,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire o_pready,
    input wire o_pslverr,
    input wire o_core_reset,
    input wire o_reset_halt_flag,
    input wire o_master_tick,
    input wire [2:0] o_frequency_error_flag,
    input wire o_any_phase_frequency_error,
    input wire [2:0] o_power_zero,
    input wire [2:0] o_energy_hold
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);

    wire remote_cmd = i_psel && i_penable && i_pwrite && o_pready &&
        (i_paddr == `LPM_CMD_OFS) && i_pwdata[`LPM_CMD_RESET_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    chk_core_after_rst: assert property ($fell(i_sys_rst) |-> o_core_reset [*3])
        else $error("core reset released right after system reset");
    chk_por_release: assert property ($fell(i_power_on_detect) |-> o_core_reset [*4])
        else $error("core reset released right after power-on");
    chk_remote_pulse: assert property (remote_cmd && !o_core_reset && !i_power_on_detect
        |-> ##[1:3] $rose(o_core_reset) ##1 !o_core_reset)
        else $error("remote reset pulse wrong");
    chk_halt_mirror: assert property (o_reset_halt_flag == o_core_reset)
        else $error("halt flag differs from core reset");
    chk_any_or: assert property (o_any_phase_frequency_error == |$past(o_frequency_error_flag))
        else $error("any-phase error is not the OR of phases");
    chk_power_zero: assert property (($stable(o_frequency_error_flag) &&
        $stable(i_single_wire_mode)) [*2] |->
        o_power_zero == (o_frequency_error_flag & ~i_single_wire_mode))
        else $error("power zero mismatch");
    chk_energy_hold: assert property (($stable(o_frequency_error_flag) &&
        $stable(i_single_wire_mode)) [*2] |->
        o_energy_hold == (o_frequency_error_flag & ~i_single_wire_mode))
        else $error("energy hold mismatch");
    chk_low_sets_error: assert property ((i_rms_voltages[11:0] < `LPM_LOW_SET) [*4]
        |-> o_frequency_error_flag[0])
        else $error("low voltage did not force error");
    chk_tick_single: assert property (o_master_tick |=> !o_master_tick)
        else $error("master tick longer than one cycle");
    chk_apb_one_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("apb answer not after one wait");
    chk_apb_unmapped: assert property (o_pready && i_paddr > `LPM_PER2_OFS |-> o_pslverr)
        else $error("unmapped access not refused");

    cover property (remote_cmd);
    cover property ($fell(o_core_reset));
    cover property (o_pslverr);
endmodule // lpm_checker

bind line_period_monitor lpm_checker u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_power_on_detect(i_power_on_detect), .i_rms_voltages(i_rms_voltages),
    .i_single_wire_mode(i_single_wire_mode), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_core_reset(o_core_reset),
    .o_reset_halt_flag(o_reset_halt_flag), .o_master_tick(o_master_tick),
    .o_frequency_error_flag(o_frequency_error_flag),
    .o_any_phase_frequency_error(o_any_phase_frequency_error),
    .o_power_zero(o_power_zero), .o_energy_hold(o_energy_hold));

// ===== dv/afe_model.sv
// Front-end model: crystal oscillator and ramped voltage samples on three phases.
`timescale 1ns/1ps

module afe_model (
    input wire i_clk,
    input wire i_load,
    input wire [15:0] i_start,
    input wire [15:0] i_step,
    input wire i_companion_clock,
    output reg o_crystal,
    output reg o_sample_valid,
    output reg [47:0] o_samples,
    output reg [31:0] o_rises,
    output reg [31:0] o_comp_edges
);
    reg [1:0] div_r;
    reg [15:0] level_r;

    initial begin
        o_crystal = 1'b0;
        o_sample_valid = 1'b0;
        o_samples = 48'h0000_0000_0000;
        o_rises = 0;
        o_comp_edges = 0;
        div_r = 2'h0;
        level_r = 16'h0000;
    end

    // Crystal at 5 MHz, unrelated to the system clock.
    always #100 o_crystal = ~o_crystal;
    always @(posedge o_crystal) o_rises <= o_rises + 1;
    always @(i_companion_clock) o_comp_edges <= o_comp_edges + 1;

    // Samples are valid only with the strobe; between strobes the lines show garbage.
    always @(posedge i_clk) begin
        div_r <= div_r + 2'h1;
        o_sample_valid <= (div_r == 2'h0);
        o_samples <= (div_r == 2'h0) ? {3{level_r}} : {3{~level_r}};
        if (i_load) begin
            level_r <= i_start;
        end else if (div_r == 2'h0) begin
            level_r <= level_r + i_step;
        end
    end
endmodule // afe_model

// ===== dv/line_period_monitor_clock_reset_bench.sv
// Self-checking bench for the line period monitor.
`timescale 1ns/1ps
`include "lpm_regs.vh"

`define CHECK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
    $display("unexpected %s expected %h seen %h", nm, exp, got); err_total++; end end

module line_period_monitor_clock_reset_bench;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_power_on_detect = 1'b0;
    logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, load = 1'b0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0000_0000;
    logic [35:0] i_rms_voltages = {3{12'h012c}};
    logic [2:0] i_single_wire_mode = 3'h0, pulse_in = 3'h0;
    logic [15:0] start = 16'h0000, step = 16'h0000;
    logic [31:0] q;
    logic e;
    wire [31:0] o_prdata, rises, comp_edges;
    wire [47:0] samples;
    wire [2:0] o_frequency_error_flag, o_power_zero, o_energy_hold;
    wire o_pready, o_pslverr, o_core_reset, o_reset_halt_flag, o_master_tick;
    wire o_companion_clock, o_motor_positive_output, o_motor_negative_output;
    wire o_energy_pulse_output, o_any_phase_frequency_error, crystal, sample_valid;
    int err_total = 0, tests_run = 0, ticks = 0, t0, r0, c0, hi;
    logic [3:0] cfgs [3] = '{4'h0, 4'h1, 4'h4};
    int lv [4] = '{300, 100, 200, 300};
    logic [2:0] lexp [4] = '{3'h0, 3'h7, 3'h7, 3'h0};
    logic [15:0] zs [4] = '{16'h03e8, 16'h4e20, 16'hfc18, 16'hb1e0};
    logic [15:0] zd [4] = '{16'h0010, 16'hfff0, 16'hfff0, 16'h0010};
    logic zexp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    always #20 i_clk = ~i_clk;
    always @(posedge i_clk) if (o_master_tick === 1'b1) ticks <= ticks + 1;

    line_period_monitor #(.POR_DELAY_TICKS(21'd16)) u_dut (.i_clk(i_clk),
        .i_sys_rst(i_sys_rst), .i_power_on_detect(i_power_on_detect),
        .i_crystal_input(crystal), .i_sample_valid(sample_valid),
        .i_voltage_samples(samples), .i_rms_voltages(i_rms_voltages),
        .i_single_wire_mode(i_single_wire_mode), .i_pulse_motor_positive(pulse_in[2]),
        .i_pulse_motor_negative(pulse_in[1]), .i_pulse_energy(pulse_in[0]),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .o_core_reset(o_core_reset),
        .o_reset_halt_flag(o_reset_halt_flag), .o_master_tick(o_master_tick),
        .o_companion_clock(o_companion_clock),
        .o_motor_positive_output(o_motor_positive_output),
        .o_motor_negative_output(o_motor_negative_output),
        .o_energy_pulse_output(o_energy_pulse_output),
        .o_frequency_error_flag(o_frequency_error_flag),
        .o_any_phase_frequency_error(o_any_phase_frequency_error),
        .o_power_zero(o_power_zero), .o_energy_hold(o_energy_hold));

    afe_model u_afe (.i_clk(i_clk), .i_load(load), .i_start(start), .i_step(step),
        .i_companion_clock(o_companion_clock), .o_crystal(crystal),
        .o_sample_valid(sample_valid), .o_samples(samples), .o_rises(rises),
        .o_comp_edges(comp_edges));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        q = o_prdata;
        e = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        if (o_pready !== 1'b1) begin
            err_total++;
            print_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        `CHECK("write error", 1'b0, e)
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        `CHECK(nm, exp, q)
    endtask

    task automatic wait_core_low();
        int n;
        for (n = 0; n < 3000 && o_core_reset !== 1'b0; n++) @(posedge i_clk);
        if (o_core_reset !== 1'b0) begin
            err_total++;
            print_verdict();
        end
    endtask

    function automatic logic near(input int a, input int b);
        return (a - b <= 2) && (b - a <= 2);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        apb(1'b0, `LPM_STAT_OFS, 32'h0000_0000);
        `CHECK("halt during delay", 1'b1, q[0])
        wait_core_low();
        rd(`LPM_CFG_OFS, 32'h0000_0000, "cfg reset");
        rd(`LPM_MODE_OFS, 32'h0000_0000, "mode reset");
        apb(1'b0, 8'h20, 32'h0000_0000);
        `CHECK("unmapped error", 1'b1, e)
        `CHECK("unmapped data", 32'h0000_0000, q)
        wr(`LPM_MODE_OFS, 32'h0000_0003);
        wr(`LPM_CFG_OFS, 32'h0000_0009);
        wr(`LPM_CMD_OFS, 32'h0000_0001);
        hi = 0;
        repeat (8) begin
            @(posedge i_clk);
            #1 hi += (o_core_reset === 1'b1);
        end
        `CHECK("remote reset width", 1, hi)
        rd(`LPM_MODE_OFS, 32'h0000_0003, "mode kept");
        rd(`LPM_CFG_OFS, 32'h0000_0000, "cfg cleared");
        // Divider select 1 with the undivided companion clock is never programmed.
        for (int k = 0; k < 3; k++) begin
            wr(`LPM_CFG_OFS, {28'h000_0000, cfgs[k]});
            repeat (10) @(posedge i_clk);
            t0 = ticks;
            r0 = rises;
            c0 = comp_edges;
            repeat (2000) @(posedge i_clk);
            `CHECK("master ticks", 1'b1, near(ticks - t0, cfgs[k][0] ? rises - r0 : 2 * (rises - r0)))
            `CHECK("companion", 1'b1, near(comp_edges - c0, cfgs[k][2] ? rises - r0 : (rises - r0) / 2))
        end
        i_power_on_detect <= 1'b1;
        repeat (5) @(posedge i_clk);
        i_power_on_detect <= 1'b0;
        repeat (10) @(posedge i_clk);
        `CHECK("por delay", 1'b1, o_core_reset)
        rd(`LPM_MODE_OFS, 32'h0000_0000, "mode after por");
        wait_core_low();
        for (int k = 0; k < 4; k++) begin
            i_rms_voltages <= {3{lv[k][11:0]}};
            repeat (20) @(posedge i_clk);
            rd(`LPM_STAT_OFS, {24'h00_0000, lexp[k], 5'h1e}, "status");
        end
        rd(`LPM_PER0_OFS, 32'h0002_0000, "period 0 default");
        rd(`LPM_PER2_OFS, 32'h0002_0000, "period 2 default");
        i_single_wire_mode <= 3'b101;
        repeat (4) @(posedge i_clk);
        `CHECK("power zero", 3'b010, o_power_zero)
        `CHECK("energy hold", 3'b010, o_energy_hold)
        wr(`LPM_CFG_OFS, 32'h0000_0008);
        wr(`LPM_MODE_OFS, 32'h0000_0001);
        pulse_in <= 3'h7;
        repeat (4) @(posedge i_clk);
        `CHECK("pulses gated", 3'h0, {o_motor_positive_output, o_motor_negative_output, o_energy_pulse_output})
        wr(`LPM_CFG_OFS, 32'h0000_0000);
        repeat (4) @(posedge i_clk);
        `CHECK("pulses free", 3'h7, {o_motor_positive_output, o_motor_negative_output, o_energy_pulse_output})
        wr(`LPM_MODE_OFS, 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            start <= zs[k];
            step <= zd[k];
            load <= 1'b1;
            @(posedge i_clk);
            load <= 1'b0;
            repeat (40) @(posedge i_clk);
            `CHECK("zero cross", zexp[k], o_motor_positive_output)
        end
        print_verdict();
    end
endmodule // line_period_monitor_clock_reset_bench
